/* sensor_sync_code_framer.v */
// Sync channel code framer with its configuration registers
`timescale 1ns/1ps
`default_nettype none
`include "sync_code_defs.vh"

// Functional notes
// - Marker word: seven writable low bits resetting to 42, three fixed upper bits.
// - Marker top bit frame versus line, next bit start, next bit end.
// - Upper marker bits come from the word kind, not from configuration.
// - Dark pixels carry a programmable code, reset 0x015, receiver classifies them.
// - Valid pixels carry a programmable code, reset 0x035, receiver takes payload.
// - Checksum code resets 0x059, align code resets 0x3a6, both decoded.
// - Per-channel dark-level fault flag set when too few dark samples existed.
// - Sixty-four read-only fault bits in four 16-bit words, low channels first.
// - Pattern select one replaces pixel data with test pattern; reset zero.
// - With no image data, align word is sent on the data lanes.

module sensor_sync_code_framer (
	// Clock and reset
	input  wire                  mclk,
	input  wire                  sys_rst,
	// Configuration port
	input  wire [8:0]            regAddr,
	input  wire                  regWrEn,
	input  wire [15:0]           regWrData,
	input  wire                  regRdEn,
	output reg  [15:0]           regRdData,
	output reg                   regRdValid,
	// Calibration result
	input  wire                  calDone,
	input  wire [63:0]           calShortSamples,
	// Pixel word source
	input  wire                  pixValid,
	output wire                  pixReady,
	input  wire [2:0]            pixKind,
	input  wire [9:0]            pixData,
	// Link
	input  wire                  pixClk,
	output reg  [9:0]            dataOut,
	output reg  [9:0]            syncOut,
	output reg                   wordStrobe
);

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg  [`LOW_W-1:0]   frameLineLow_reg;
	reg  [`CODE_W-1:0]  darkPixelMarkerCode_reg;
	reg  [`CODE_W-1:0]  validPixelMarker_reg;
	reg  [`CODE_W-1:0]  checksumWordMarker_reg;
	reg  [`CODE_W-1:0]  alignWordMarkerCode_reg;
	reg  [`FAULT_W-1:0] darkLevelFault_reg;
	reg  [`REG_W-1:0]   spareWordA_reg;
	reg  [`REG_W-1:0]   spareWordB_reg;
	reg                 patternEnable_reg;
	reg  [`REG_W-1:0]   rdData_next;
	reg                 rdHit_next;

	always @(posedge mclk) begin
		if (sys_rst) begin
			frameLineLow_reg        <= `RST_FRAME_LINE_LOW;
			darkPixelMarkerCode_reg <= `RST_DARK_PIXEL_MARKER;
			validPixelMarker_reg    <= `RST_VALID_PIXEL_MARKER;
			checksumWordMarker_reg  <= `RST_CHECKSUM_WORD_MARKER;
			alignWordMarkerCode_reg <= `RST_ALIGN_WORD_MARKER;
			spareWordA_reg          <= `RST_SPARE_WORD_A;
			spareWordB_reg          <= `RST_SPARE_WORD_B;
			patternEnable_reg       <= `RST_PATTERN_ENABLE;
		end else if (regWrEn) begin
			case (regAddr)
				`ADDR_FRAME_LINE_MARKER: begin
					frameLineLow_reg <= regWrData[`LOW_W-1:0];
				end
				`ADDR_DARK_PIXEL_MARKER: begin
					darkPixelMarkerCode_reg <= regWrData[`CODE_W-1:0];
				end
				`ADDR_VALID_PIXEL_MARKER: begin
					validPixelMarker_reg <= regWrData[`CODE_W-1:0];
				end
				`ADDR_CHECKSUM_WORD_MARKER: begin
					checksumWordMarker_reg <= regWrData[`CODE_W-1:0];
				end
				`ADDR_ALIGN_WORD_MARKER: begin
					alignWordMarkerCode_reg <= regWrData[`CODE_W-1:0];
				end
				`ADDR_SPARE_WORD_A: begin
					spareWordA_reg <= regWrData;
				end
				`ADDR_SPARE_WORD_B: begin
					spareWordB_reg <= regWrData;
				end
				`ADDR_PATTERN_TEST_CONTROL: begin
					patternEnable_reg <= regWrData[`PATTERN_BIT];
				end
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------
	// Dark-level fault flags
	// ----------------------------------------
	always @(posedge mclk) begin
		if (sys_rst) begin
			darkLevelFault_reg <= {4{`RST_DARK_FAULT}};
		end else if (calDone) begin
			darkLevelFault_reg <= calShortSamples;
		end
	end

	// ----------------------------------------
	// Register read
	// ----------------------------------------
	always @* begin
		rdData_next = `READ_ZERO;
		rdHit_next  = 1'b1;
		case (regAddr)
			`ADDR_FRAME_LINE_MARKER: begin
				rdData_next = {`PAD_LOW, frameLineLow_reg};
			end
			`ADDR_DARK_PIXEL_MARKER: begin
				rdData_next = {`PAD_CODE, darkPixelMarkerCode_reg};
			end
			`ADDR_VALID_PIXEL_MARKER: begin
				rdData_next = {`PAD_CODE, validPixelMarker_reg};
			end
			`ADDR_CHECKSUM_WORD_MARKER: begin
				rdData_next = {`PAD_CODE, checksumWordMarker_reg};
			end
			`ADDR_ALIGN_WORD_MARKER: begin
				rdData_next = {`PAD_CODE, alignWordMarkerCode_reg};
			end
			`ADDR_DARK_FAULT_CH0_15: begin
				rdData_next = darkLevelFault_reg[`FAULT_LSB_CH0 +: `REG_W];
			end
			`ADDR_DARK_FAULT_CH16_31: begin
				rdData_next = darkLevelFault_reg[`FAULT_LSB_CH16 +: `REG_W];
			end
			`ADDR_DARK_FAULT_CH32_47: begin
				rdData_next = darkLevelFault_reg[`FAULT_LSB_CH32 +: `REG_W];
			end
			`ADDR_DARK_FAULT_CH48_63: begin
				rdData_next = darkLevelFault_reg[`FAULT_LSB_CH48 +: `REG_W];
			end
			`ADDR_SPARE_WORD_A: begin
				rdData_next = spareWordA_reg;
			end
			`ADDR_SPARE_WORD_B: begin
				rdData_next = spareWordB_reg;
			end
			`ADDR_PATTERN_TEST_CONTROL: begin
				rdData_next = {`PAD_TEST, patternEnable_reg};
			end
			default: begin
				rdHit_next = 1'b0;
			end
		endcase
	end

	always @(posedge mclk) begin
		if (sys_rst) begin
			regRdData  <= `READ_ZERO;
			regRdValid <= 1'b0;
		end else begin
			regRdValid <= regRdEn;
			if (regRdEn) begin
				regRdData <= rdHit_next ? rdData_next : `READ_ZERO;
			end
		end
	end

	// ----------------------------------------
	// Link clock sampling
	// ----------------------------------------
	reg  pixClkMeta_reg;
	reg  pixClkSync_reg;
	reg  pixClkLast_reg;
	wire slot;

	always @(posedge mclk) begin
		if (sys_rst) begin
			pixClkMeta_reg <= 1'b0;
			pixClkSync_reg <= 1'b0;
			pixClkLast_reg <= 1'b0;
		end else begin
			pixClkMeta_reg <= pixClk;
			pixClkSync_reg <= pixClkMeta_reg;
			pixClkLast_reg <= pixClkSync_reg;
		end
	end

	assign slot = pixClkSync_reg & ~pixClkLast_reg;

	// ----------------------------------------
	// Word buffer
	// ----------------------------------------
	wire               bufValid;
	wire [`ENTRY_W-1:0] bufData;
	wire [`KIND_W-1:0] bufKind;
	wire [`CODE_W-1:0] bufWord;

	sync_word_fifo #(
		.WIDTH (`ENTRY_W),
		.DEPTH (`FIFO_DEPTH),
		.AW    (`FIFO_AW)
	) wordBuffer (
		.mclk     (mclk),
		.sys_rst  (sys_rst),
		.inValid  (pixValid),
		.inReady  (pixReady),
		.inData   ({pixKind, pixData}),
		.outValid (bufValid),
		.outReady (slot),
		.outData  (bufData)
	);

	assign bufKind = bufData[`ENTRY_W-1:`CODE_W];
	assign bufWord = bufData[`CODE_W-1:0];

	// ----------------------------------------
	// Marker boundary bits
	// ----------------------------------------
	reg  [`MARK_W-1:0] markTop_next;

	always @* begin
		markTop_next = `MARK_NONE;
		case (bufKind)
			`KIND_FRAME_START: begin
				markTop_next = `MARK_FRAME_START;
			end
			`KIND_FRAME_END: begin
				markTop_next = `MARK_FRAME_END;
			end
			`KIND_LINE_START: begin
				markTop_next = `MARK_LINE_START;
			end
			`KIND_LINE_END: begin
				markTop_next = `MARK_LINE_END;
			end
			default: begin
				markTop_next = `MARK_NONE;
			end
		endcase
	end

	// ----------------------------------------
	// Sync code selection
	// ----------------------------------------
	reg  [`CODE_W-1:0] syncCode_next;
	reg  [`CODE_W-1:0] data_next;
	reg  [`CODE_W-1:0] pattern_reg;

	always @* begin
		syncCode_next = alignWordMarkerCode_reg;
		case (bufKind)
			`KIND_FRAME_START: begin
				syncCode_next = {markTop_next, frameLineLow_reg};
			end
			`KIND_FRAME_END: begin
				syncCode_next = {markTop_next, frameLineLow_reg};
			end
			`KIND_LINE_START: begin
				syncCode_next = {markTop_next, frameLineLow_reg};
			end
			`KIND_LINE_END: begin
				syncCode_next = {markTop_next, frameLineLow_reg};
			end
			`KIND_DARK: begin
				syncCode_next = darkPixelMarkerCode_reg;
			end
			`KIND_VALID: begin
				syncCode_next = validPixelMarker_reg;
			end
			`KIND_CHECKSUM: begin
				syncCode_next = checksumWordMarker_reg;
			end
			default: begin
				syncCode_next = alignWordMarkerCode_reg;
			end
		endcase
		if (patternEnable_reg) begin
			data_next = pattern_reg;
		end else begin
			data_next = bufWord;
		end
	end

	// ----------------------------------------
	// Link output
	// ----------------------------------------
	always @(posedge mclk) begin
		if (sys_rst) begin
			dataOut     <= `RST_ALIGN_WORD_MARKER;
			syncOut     <= `RST_ALIGN_WORD_MARKER;
			wordStrobe  <= 1'b0;
			pattern_reg <= `PATTERN_START;
		end else begin
			wordStrobe <= slot;
			if (slot) begin
				if (bufValid) begin
					dataOut <= data_next;
					syncOut <= syncCode_next;
					if (patternEnable_reg) begin
						pattern_reg <= pattern_reg + `PATTERN_STEP;
					end
				end else begin
					dataOut <= alignWordMarkerCode_reg;
					syncOut <= alignWordMarkerCode_reg;
				end
			end
		end
	end

endmodule

`default_nettype wire

/* sync_code_defs.vh */
// Constants for the sync code framer: register map, fields, resets and word kinds
`ifndef SYNC_CODE_DEFS_VH
`define SYNC_CODE_DEFS_VH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define ADDR_FRAME_LINE_MARKER     9'h083
`define ADDR_DARK_PIXEL_MARKER     9'h084
`define ADDR_VALID_PIXEL_MARKER    9'h085
`define ADDR_CHECKSUM_WORD_MARKER  9'h086
`define ADDR_ALIGN_WORD_MARKER     9'h087
`define ADDR_DARK_FAULT_CH0_15     9'h088
`define ADDR_DARK_FAULT_CH16_31    9'h089
`define ADDR_DARK_FAULT_CH32_47    9'h08a
`define ADDR_DARK_FAULT_CH48_63    9'h08b
`define ADDR_SPARE_WORD_A          9'h08c
`define ADDR_SPARE_WORD_B          9'h08d
`define ADDR_PATTERN_TEST_CONTROL  9'h090

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_FRAME_LINE_LOW         7'h2a
`define RST_DARK_PIXEL_MARKER      10'h015
`define RST_VALID_PIXEL_MARKER     10'h035
`define RST_CHECKSUM_WORD_MARKER   10'h059
`define RST_ALIGN_WORD_MARKER      10'h3a6
`define RST_DARK_FAULT             16'h0000
`define RST_SPARE_WORD_A           16'h0000
`define RST_SPARE_WORD_B           16'hffff
`define RST_PATTERN_ENABLE         1'b0

// ----------------------------------------
// Field layout
// ----------------------------------------
`define CODE_W                     10
`define LOW_W                      7
`define REG_W                      16
`define FAULT_W                    64
`define KIND_W                     3
`define ENTRY_W                    13
`define FIFO_DEPTH                 4
`define PAD_CODE                   6'h00
`define PAD_LOW                    9'h000
`define PAD_TEST                   15'h0000
`define READ_ZERO                  16'h0000
`define PATTERN_STEP               10'h001
`define PATTERN_START              10'h000
`define PATTERN_BIT                0
`define FIFO_AW                    2
`define FAULT_LSB_CH0              0
`define FAULT_LSB_CH16             16
`define FAULT_LSB_CH32             32
`define FAULT_LSB_CH48             48

// ----------------------------------------
// Marker upper bits: frame/line, start, end
// ----------------------------------------
`define MARK_W                     3
`define MARK_FRAME_START           3'h6
`define MARK_FRAME_END             3'h5
`define MARK_LINE_START            3'h2
`define MARK_LINE_END              3'h1
`define MARK_NONE                  3'h0

// ----------------------------------------
// Word kinds carried with each data word
// ----------------------------------------
`define KIND_FRAME_START           3'h0
`define KIND_FRAME_END             3'h1
`define KIND_LINE_START            3'h2
`define KIND_LINE_END              3'h3
`define KIND_DARK                  3'h4
`define KIND_VALID                 3'h5
`define KIND_CHECKSUM              3'h6
`define KIND_ALIGN                 3'h7

`endif

/* sync_word_fifo.v */
// Small flip-flop FIFO for kind and data words
`timescale 1ns/1ps
`default_nettype none

module sync_word_fifo #(
	parameter WIDTH = 13,
	parameter DEPTH = 4,
	parameter AW    = 2
) (
	// Clock and reset
	input  wire             mclk,
	input  wire             sys_rst,
	// Fill side
	input  wire             inValid,
	output wire             inReady,
	input  wire [WIDTH-1:0] inData,
	// Drain side
	output wire             outValid,
	input  wire             outReady,
	output wire [WIDTH-1:0] outData
);

	reg  [WIDTH-1:0] store_reg [0:DEPTH-1];
	reg  [AW-1:0]    wrPtr_reg;
	reg  [AW-1:0]    rdPtr_reg;
	reg  [AW:0]      count_reg;
	wire             doWrite;
	wire             doRead;

	assign inReady  = (count_reg != DEPTH[AW:0]);
	assign outValid = (count_reg != {(AW+1){1'b0}});
	assign outData  = store_reg[rdPtr_reg];
	assign doWrite  = inValid & inReady;
	assign doRead   = outValid & outReady;

	always @(posedge mclk) begin
		if (doWrite) begin
			store_reg[wrPtr_reg] <= inData;
		end
	end

	always @(posedge mclk) begin
		if (sys_rst) begin
			wrPtr_reg <= {AW{1'b0}};
			rdPtr_reg <= {AW{1'b0}};
			count_reg <= {(AW+1){1'b0}};
		end else begin
			if (doWrite) begin
				wrPtr_reg <= wrPtr_reg + {{(AW-1){1'b0}}, 1'b1};
			end
			if (doRead) begin
				rdPtr_reg <= rdPtr_reg + {{(AW-1){1'b0}}, 1'b1};
			end
			if (doWrite & ~doRead) begin
				count_reg <= count_reg + {{AW{1'b0}}, 1'b1};
			end else if (doRead & ~doWrite) begin
				count_reg <= count_reg - {{AW{1'b0}}, 1'b1};
			end
		end
	end

endmodule

`default_nettype wire

/* sync_code_framer_monitor.sv */
// Concurrent checks on the sync code framer ports
`timescale 1ns/1ps
`default_nettype none
module sync_code_framer_monitor (
	// Clock and reset
	input wire logic        mclk,
	input wire logic        sys_rst,
	// Configuration port
	input wire logic [8:0]  regAddr,
	input wire logic        regRdEn,
	input wire logic [15:0] regRdData,
	input wire logic        regRdValid,
	// Calibration
	input wire logic        calDone,
	input wire logic [63:0] calShortSamples,
	// Link
	input wire logic        pixClk,
	input wire logic [9:0]  dataOut,
	input wire logic [9:0]  syncOut,
	input wire logic        wordStrobe
);
	logic [63:0] fltReg;
	logic [15:0] fltWord;
	always @(posedge mclk) begin
		if (sys_rst)
			fltReg <= 64'h0;
		else if (calDone)
			fltReg <= calShortSamples;
	end
	assign fltWord = fltReg[{regAddr[1:0], 4'h0} +: 16];
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	property p_rdAnswer; regRdEn |=> regRdValid; endproperty
	a_rdAnswer: assert property (p_rdAnswer) else $error("read not answered");
	property p_rdQuiet; !regRdEn |=> !regRdValid; endproperty
	a_rdQuiet: assert property (p_rdQuiet) else $error("read valid without request");
	property p_rdHold; !regRdValid |-> $stable(regRdData); endproperty
	a_rdHold: assert property (p_rdHold) else $error("read data moved");
	property p_fault; regRdEn && regAddr[8:2] == 7'h22 && !calDone |=> regRdData == $past(fltWord);
	endproperty
	a_fault: assert property (p_fault) else $error("fault word wrong");
	property p_unmapped; regRdEn && regAddr[8:1] == 8'h47 |=> regRdData == 16'h0000; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_idle; $fell(sys_rst) |-> dataOut == 10'h3a6 && syncOut == 10'h3a6; endproperty
	a_idle: assert property (p_idle) else $error("idle word wrong after reset");
	property p_slot; $rose(pixClk) |-> ##[1:5] wordStrobe; endproperty
	a_slot: assert property (p_slot) else $error("no word for link slot");
	property p_gap; wordStrobe |=> !wordStrobe [*8]; endproperty
	a_gap: assert property (p_gap) else $error("words too close");
	property p_pair; !wordStrobe |-> $stable(dataOut) && $stable(syncOut); endproperty
	a_pair: assert property (p_pair) else $error("lane moved off slot");
endmodule
`default_nettype wire

/* sync_receiver_model.sv */
// Receiver model that classifies link words by their sync code
`timescale 1ns/1ps
`default_nettype none
module sync_receiver_model (
	// Clock
	input wire logic       mclk,
	// Link
	input wire logic [9:0] dataOut,
	input wire logic [9:0] syncOut,
	input wire logic       wordStrobe,
	// Expected codes
	input wire logic [9:0] darkCode,
	input wire logic [9:0] validCode,
	input wire logic [9:0] sumCode,
	input wire logic [9:0] alignCode,
	input wire logic [6:0] markLow
);
	logic [12:0] q[$];
	logic [2:0]  k;
	int          seen = 0;
	int          bad = 0;
	always @(posedge mclk) begin
		if (wordStrobe === 1'b1) begin
			k = 3'h7;
			if (syncOut === darkCode) k = 3'h4;
			else if (syncOut === validCode) k = 3'h5;
			else if (syncOut === sumCode) k = 3'h6;
			else if (syncOut[6:0] === markLow) begin
				case (syncOut[9:7])
					3'b110: k = 3'h0;
					3'b101: k = 3'h1;
					3'b010: k = 3'h2;
					3'b001: k = 3'h3;
					default: k = 3'h7;
				endcase
			end
			if (syncOut === alignCode) seen++;
			else if (k == 3'h7) bad++;
			else q.push_back({k, dataOut});
		end
	end
endmodule
`default_nettype wire

/* sensor_sync_code_framer_tb.sv */
// Testbench for the sync code framer
`timescale 1ns/1ps
`default_nettype none
module sensor_sync_code_framer_tb;
	logic mclk = 1'b0, sys_rst = 1'b1, pixClk = 1'b0;
	logic [8:0] regAddr = 9'h000;
	logic regWrEn = 1'b0, regRdEn = 1'b0, regRdValid, calDone = 1'b0;
	logic [15:0] regWrData = 16'h0000, regRdData;
	logic [63:0] calShortSamples = 64'h0;
	logic pixValid = 1'b0, pixReady, wordStrobe, fullSeen = 1'b0;
	logic [2:0] pixKind = 3'h0;
	logic [9:0] pixData = 10'h000, dataOut, syncOut;
	logic [9:0] darkCode = 10'h015, validCode = 10'h035, sumCode = 10'h059;
	logic [6:0] markLow = 7'h2a;
	logic [15:0] rv [0:10] = '{16'h002a, 16'h0015, 16'h0035, 16'h0059, 16'h03a6,
		16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'hffff};
	int fails = 0, checks = 0, i;
	sensor_sync_code_framer uut (.mclk(mclk), .sys_rst(sys_rst), .regAddr(regAddr),
		.regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
		.regRdValid(regRdValid), .calDone(calDone), .calShortSamples(calShortSamples),
		.pixValid(pixValid), .pixReady(pixReady), .pixKind(pixKind), .pixData(pixData),
		.pixClk(pixClk), .dataOut(dataOut), .syncOut(syncOut), .wordStrobe(wordStrobe));
	sync_receiver_model rx (.mclk(mclk), .dataOut(dataOut), .syncOut(syncOut),
		.wordStrobe(wordStrobe), .darkCode(darkCode), .validCode(validCode),
		.sumCode(sumCode), .alignCode(10'h3a6), .markLow(markLow));
	always #5 mclk = ~mclk;
	always #80 pixClk = ~pixClk;
	task results;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task wr(input logic [8:0] a, input logic [15:0] d);
		@(posedge mclk);
		#1 regAddr = a;
		regWrData = d;
		regWrEn = 1'b1;
		@(posedge mclk);
		#1 regWrEn = 1'b0;
	endtask
	task rd(input logic [8:0] a, input logic [15:0] exp);
		@(posedge mclk);
		#1 regAddr = a;
		regRdEn = 1'b1;
		@(posedge mclk);
		#1 regRdEn = 1'b0;
		chk("regRdValid", 16'h0001, {15'h0, regRdValid});
		chk("regRdData", exp, regRdData);
	endtask
	task push(input logic [2:0] k, input logic [9:0] d);
		int n;
		pixKind = k;
		pixData = d;
		pixValid = 1'b1;
		n = 0;
		while (pixReady !== 1'b1 && n < 200) begin
			fullSeen = 1'b1;
			@(posedge mclk);
			#1;
			n++;
		end
		@(posedge mclk);
		#1;
		if (n >= 200) begin
			fails++;
			results();
		end
	endtask
	task waitq(input int n);
		int t;
		t = 0;
		while (rx.q.size() < n && t < 2000) begin
			@(posedge mclk);
			t++;
		end
		#1;
		if (t >= 2000) begin
			fails++;
			results();
		end
	endtask
	initial begin
		repeat (10) @(posedge mclk);
		#1 sys_rst = 1'b0;
		repeat (40) @(posedge mclk);
		chk("idleData", 16'h03a6, {6'h00, dataOut});
		chk("idleSync", 16'h03a6, {6'h00, syncOut});
		chk("alignSeen", 16'h0001, {15'h0, rx.seen > 0});
		for (i = 0; i < 11; i++) rd(9'(9'h083 + i), rv[i]);
		rd(9'h090, 16'h0000);
		rd(9'h08e, 16'h0000);
		wr(9'h090, 16'hffff);
		rd(9'h090, 16'h0001);
		for (i = 0; i < 3; i++) push(3'h5, 10'h123);
		pixValid = 1'b0;
		waitq(3);
		for (i = 0; i < 3; i++) chk("pattern", 16'(16'h1400 + i), {3'h0, rx.q.pop_front()});
		wr(9'h090, 16'h0000);
		push(3'h5, 10'h155);
		pixValid = 1'b0;
		waitq(1);
		chk("pixel", 16'h1555, {3'h0, rx.q.pop_front()});
		wr(9'h083, 16'hffff);
		rd(9'h083, 16'h007f);
		wr(9'h084, 16'hffff);
		rd(9'h084, 16'h03ff);
		wr(9'h083, 16'h0055);
		wr(9'h084, 16'h02c1);
		wr(9'h085, 16'h01e3);
		wr(9'h086, 16'h0099);
		markLow = 7'h55;
		darkCode = 10'h2c1;
		validCode = 10'h1e3;
		sumCode = 10'h099;
		rd(9'h085, 16'h01e3);
		rd(9'h086, 16'h0099);
		calShortSamples = 64'h8000_00f0_a5c3_0001;
		calDone = 1'b1;
		@(posedge mclk);
		#1 calDone = 1'b0;
		for (i = 0; i < 4; i++) rd(9'(9'h088 + i), calShortSamples[16 * i +: 16]);
		wr(9'h088, 16'h0000);
		rd(9'h088, 16'h0001);
		for (i = 0; i < 8; i++) push(3'(i), 10'(10'h200 + 7 * i));
		pixValid = 1'b0;
		chk("fullSeen", 16'h0001, {15'h0, fullSeen});
		waitq(7);
		for (i = 0; i < 7; i++) chk("word", 16'((i << 10) + 10'h200 + 7 * i), {3'h0, rx.q.pop_front()});
		chk("badCodes", 16'h0000, 16'(rx.bad));
		wr(9'h08c, 16'h5a3c);
		rd(9'h08c, 16'h5a3c);
		wr(9'h087, 16'h02b4);
		rd(9'h087, 16'h02b4);
		repeat (48) @(posedge mclk);
		#1;
		chk("alignData", 16'h02b4, {6'h00, dataOut});
		chk("alignSync", 16'h02b4, {6'h00, syncOut});
		results();
	end
endmodule
bind sensor_sync_code_framer sync_code_framer_monitor mon (.mclk(mclk), .sys_rst(sys_rst),
	.regAddr(regAddr), .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid),
	.calDone(calDone), .calShortSamples(calShortSamples), .pixClk(pixClk),
	.dataOut(dataOut), .syncOut(syncOut), .wordStrobe(wordStrobe));
`default_nettype wire
